/* File: design/prilt_pkg.sv */
`default_nettype none
package prilt_pkg;

  // Clock
  localparam int CLK_NS = 40;

  // Reset, isolate, loopback and line timing, figures in their own units
  localparam int STRAP_US = 3;
  localparam int DRV_NS = 50;
  localparam int ISO_CLR_US = 100;
  localparam int RST_ISO_US = 500;
  localparam int DEAD_US = 550;
  localparam int BIT_NS = 10;
  localparam int CRS_BITS_X10 = 175;

  // Derived cycle counts: least times round up, longest round down
  localparam int STRAP_CYC = (STRAP_US * 1000) / CLK_NS;
  localparam int DRV_CYC = (DRV_NS + CLK_NS - 1) / CLK_NS;
  localparam int ISO_CLR_CYC = (ISO_CLR_US * 1000) / CLK_NS;
  localparam int RST_ISO_CYC = (RST_ISO_US * 1000) / CLK_NS;
  localparam int LBK_DEAD_CYC = (DEAD_US * 1000) / CLK_NS;
  localparam int CRS_MAX_CYC = (CRS_BITS_X10 * BIT_NS) / (10 * CLK_NS);

  // Register map, byte addresses
  localparam int AXI_AW = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LOOP_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] STRAP_OFS = 8'h0C;

  // Field positions
  localparam int CTRL_ISO_BIT = 10;
  localparam int CTRL_LBK_BIT = 14;
  localparam int CTRL_SRST_BIT = 15;
  localparam int LOOP_XMT_BIT = 0;
  localparam int STAT_ISO_BIT = 0;
  localparam int STAT_LATCH_BIT = 1;
  localparam int STAT_DRIVE_BIT = 2;
  localparam int STAT_DEAD_BIT = 3;
  localparam int STAT_CRS_BIT = 4;
  localparam int STRAP_ISO_BIT = 0;

  // Responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Line code groups
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_IDLE = 5'h1F;
  localparam logic [4:0] CG_OFF = 5'h00;

  typedef enum logic [1:0] {SEQ_WAIT, SEQ_DRIVE, SEQ_RUN} prilt_seq_t;
  typedef enum logic [1:0] {RX_IDLE, RX_SSD, RX_DATA} prilt_rx_t;

endpackage
`default_nettype wire

/* File: design/prilt_fifo.sv */
`default_nettype none
module prilt_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic flush,
  // Fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || WIDTH < 1) begin : g_chk
    $error("prilt_fifo: DEPTH must be at least 2 and WIDTH at least 1");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  assign outData = mem_q[rdPtr_q];

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = (AW + 1)'(count_q + 1'b1);
    end else if (pop && !push) begin
      count_d = (AW + 1)'(count_q - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  // Flags are registered so the ready seen by the source has no long path
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      inReady <= 1'b1;
      outValid <= 1'b0;
    end else if (flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      inReady <= 1'b1;
      outValid <= 1'b0;
    end else begin
      if (push) begin
        wrPtr_q <= nextPtr(wrPtr_q);
      end
      if (pop) begin
        rdPtr_q <= nextPtr(rdPtr_q);
      end
      count_q <= count_d;
      inReady <= (count_d != (AW + 1)'(DEPTH));
      outValid <= (count_d != '0);
    end
  end
endmodule
`default_nettype wire

/* File: design/prilt_top.sv */
// How it works
// R1: Carrier sense within 17.5 bits of J.
// R2: Hardware reset held at least 140 us.
// R3: Management waits 3 us before preamble.
// R4: Preamble is 32 ones on data line.
// R5: Straps sampled 3 us after reset release.
// R6: Strap pins become outputs 50 ns later.
// R7: No software reset within 500 us.
// R8: Loopback blanks receive up to 550 us.
// R9: Line transmit quiet during loopback by default.
// R10: Loopback transmit enable bit 0 drives line.
// R11: Clearing isolate bit 10 resumes within 100 us.
// R12: Reset leaves isolate within 500 us.
// R13: Post-reset intervals counted on reference clock.
`default_nettype none
module prilt_top
  import prilt_pkg::*;
#(
  parameter int STRAP_W = 4,
  parameter int FIFO_DEPTH = 4,
  parameter int DEAD_CYCLES = LBK_DEAD_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // AXI4-Lite write
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Dual-purpose configuration pins
  input wire logic [STRAP_W-1:0] cfgPinIn,
  output logic [STRAP_W-1:0] cfgPinOut,
  output logic [STRAP_W-1:0] cfgPinOe_b,
  // MAC transmit
  input wire logic macTxEn,
  input wire logic [3:0] macTxd,
  output logic macTxReady,
  // MAC receive
  output logic macRxDv,
  output logic [3:0] macRxd,
  output logic macCrs,
  // Line pairs, one code group per clock
  input wire logic [4:0] lineRxCode,
  output logic [4:0] lineTxCode,
  output logic lineTxActive,
  input wire logic lineTxReady
);
  localparam int DEAD_W = $clog2(DEAD_CYCLES + 1);
  localparam int SEQ_W = $clog2(STRAP_CYC + 1);
  localparam int SINCE_W = $clog2(RST_ISO_CYC + 1);
  localparam int CRS_LIM = CRS_MAX_CYC;
  localparam int DRV_LIM = DRV_CYC;

  if (STRAP_W < 1 || DEAD_CYCLES < 1 || FIFO_DEPTH < 2) begin : g_chk
    $error("prilt_top: STRAP_W, DEAD_CYCLES or FIFO_DEPTH out of range");
  end

  function automatic logic [4:0] enc4b5b(input logic [3:0] n);
    case (n)
      4'h0: return 5'h1E;
      4'h1: return 5'h09;
      4'h2: return 5'h14;
      4'h3: return 5'h15;
      4'h4: return 5'h0A;
      4'h5: return 5'h0B;
      4'h6: return 5'h0E;
      4'h7: return 5'h0F;
      4'h8: return 5'h12;
      4'h9: return 5'h13;
      4'hA: return 5'h16;
      4'hB: return 5'h17;
      4'hC: return 5'h1A;
      4'hD: return 5'h1B;
      4'hE: return 5'h1C;
      default: return 5'h1D;
    endcase
  endfunction

  // Decoding by search keeps the table written once
  function automatic logic [3:0] dec5b4b(input logic [4:0] c);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (enc4b5b(4'(i)) == c) begin
        n = 4'(i);
      end
    end
    return n;
  endfunction

  function automatic logic [31:0] mergeWord(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (data & m) | (old & ~m);
  endfunction

  logic ctrlIso_q;
  logic lbk_q;
  logic lbkXmt_q;
  logic [STRAP_W-1:0] strap_q;
  prilt_seq_t seqPh_q;
  logic [SEQ_W-1:0] seqCnt_q;
  logic isoActive_q;
  logic [DEAD_W-1:0] deadCnt_q;
  logic lbkPrev_q;
  prilt_rx_t rxSt_q;
  prilt_rx_t rxSt_d;
  logic [SINCE_W-1:0] since_q;
  logic wrTake;
  logic srstNow;
  logic [31:0] ctrlWord;
  logic [31:0] ctrlNew;
  logic [31:0] loopNew;
  logic [31:0] rdWord;
  logic rdOk;
  logic fifoOutValid;
  logic [3:0] fifoOutData;
  logic fifoOutReady;
  logic fifoPop;
  logic deadDone;

  // Register bus: write address and data are taken together
  assign wrTake = s_axi_awready;
  always_comb begin
    ctrlWord = '0;
    ctrlWord[CTRL_ISO_BIT] = ctrlIso_q;
    ctrlWord[CTRL_LBK_BIT] = lbk_q;
    ctrlNew = mergeWord(ctrlWord, s_axi_wdata, s_axi_wstrb);
    loopNew = mergeWord({31'h0, lbkXmt_q}, s_axi_wdata, s_axi_wstrb);
  end
  assign srstNow = wrTake && s_axi_awaddr == CTRL_OFS &&
                   ctrlNew[CTRL_SRST_BIT];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                       !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                      !s_axi_bvalid;
      if (wrTake) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (s_axi_awaddr == CTRL_OFS || s_axi_awaddr == LOOP_OFS ||
                        s_axi_awaddr == STAT_OFS || s_axi_awaddr == STRAP_OFS)
                       ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rdWord = '0;
    rdOk = 1'b1;
    case (s_axi_araddr)
      CTRL_OFS: begin
        rdWord = ctrlWord;
        rdWord[CTRL_SRST_BIT] = (seqPh_q != SEQ_RUN);
      end
      LOOP_OFS: rdWord[LOOP_XMT_BIT] = lbkXmt_q;
      STAT_OFS: begin
        rdWord[STAT_ISO_BIT] = isoActive_q;
        rdWord[STAT_LATCH_BIT] = (seqPh_q != SEQ_WAIT);
        rdWord[STAT_DRIVE_BIT] = (seqPh_q == SEQ_RUN);
        rdWord[STAT_DEAD_BIT] = lbk_q && !deadDone;
        rdWord[STAT_CRS_BIT] = macCrs;
      end
      STRAP_OFS: rdWord[STRAP_W-1:0] = strap_q;
      default: rdOk = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdWord;
        s_axi_rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Control bits; a software reset returns them to defaults
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlIso_q <= 1'b0;
      lbk_q <= 1'b0;
      lbkXmt_q <= 1'b0;
    end else if (srstNow) begin
      ctrlIso_q <= 1'b0;
      lbk_q <= 1'b0;
      lbkXmt_q <= 1'b0;
    end else if (seqPh_q == SEQ_WAIT &&
                 seqCnt_q == SEQ_W'(STRAP_CYC - 1)) begin
      ctrlIso_q <= cfgPinIn[STRAP_ISO_BIT];
    end else if (wrTake && s_axi_awaddr == CTRL_OFS) begin
      ctrlIso_q <= ctrlNew[CTRL_ISO_BIT]; // [R11]
      lbk_q <= ctrlNew[CTRL_LBK_BIT];
    end else if (wrTake && s_axi_awaddr == LOOP_OFS) begin
      lbkXmt_q <= loopNew[LOOP_XMT_BIT]; // [R10]
    end
  end

  // Reset sequence counted on the reference clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seqPh_q <= SEQ_WAIT;
      seqCnt_q <= '0;
      strap_q <= '0;
      cfgPinOe_b <= '1;
    end else if (srstNow) begin
      seqPh_q <= SEQ_WAIT;
      seqCnt_q <= '0;
      cfgPinOe_b <= '1;
    end else begin
      case (seqPh_q)
        SEQ_WAIT: begin
          seqCnt_q <= SEQ_W'(seqCnt_q + 1'b1); // [R13]
          if (seqCnt_q == SEQ_W'(STRAP_CYC - 1)) begin
            strap_q <= cfgPinIn; // [R5]
            seqPh_q <= SEQ_DRIVE;
            seqCnt_q <= '0;
          end
        end
        SEQ_DRIVE: begin
          seqCnt_q <= SEQ_W'(seqCnt_q + 1'b1);
          if (seqCnt_q == SEQ_W'(DRV_CYC - 1)) begin
            cfgPinOe_b <= '0; // [R6]
            seqPh_q <= SEQ_RUN;
          end
        end
        SEQ_RUN: seqCnt_q <= '0;
        default: seqPh_q <= SEQ_WAIT;
      endcase
    end
  end

  // Once driven, the strap pins show the values they were strapped to
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfgPinOut <= '0;
    end else begin
      cfgPinOut <= strap_q;
    end
  end

  // Isolation ends as soon as the straps are in unless the isolate strap is set, well inside the limit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      isoActive_q <= 1'b1;
    end else begin
      isoActive_q <= ctrlIso_q || seqPh_q == SEQ_WAIT || srstNow; // [R12]
    end
  end

  // Descrambler dead-time on each entry to loopback
  assign deadDone = (deadCnt_q == '0);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lbkPrev_q <= 1'b0;
      deadCnt_q <= '0;
    end else begin
      lbkPrev_q <= lbk_q;
      if (lbk_q && !lbkPrev_q) begin
        deadCnt_q <= DEAD_W'(DEAD_CYCLES); // [R8]
      end else if (!deadDone) begin
        deadCnt_q <= DEAD_W'(deadCnt_q - 1'b1);
      end
    end
  end

  // Transmit path; the line side may stall and fill the FIFO
  assign fifoOutReady = lbk_q || lineTxReady;
  assign fifoPop = fifoOutValid && fifoOutReady;

  prilt_fifo #(
    .WIDTH(4),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .flush(srstNow),
    .inValid(macTxEn && !isoActive_q),
    .inData(macTxd),
    .inReady(macTxReady),
    .outValid(fifoOutValid),
    .outData(fifoOutData),
    .outReady(fifoOutReady)
  );

  // Framing code groups on the line are left to the stage beyond
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lineTxActive <= 1'b0;
      lineTxCode <= CG_OFF;
    end else if (isoActive_q || (lbk_q && !lbkXmt_q)) begin
      lineTxActive <= 1'b0; // [R9]
      lineTxCode <= CG_OFF;
    end else begin
      lineTxActive <= 1'b1; // [R10]
      lineTxCode <= fifoPop ? enc4b5b(fifoOutData) : CG_IDLE;
    end
  end

  // Receive framing from the line
  always_comb begin
    rxSt_d = rxSt_q;
    case (rxSt_q)
      RX_IDLE: if (lineRxCode == CG_J) rxSt_d = RX_SSD;
      RX_SSD: rxSt_d = (lineRxCode == CG_K) ? RX_DATA : RX_IDLE;
      RX_DATA: begin
        if (lineRxCode == CG_T || lineRxCode == CG_IDLE) begin
          rxSt_d = RX_IDLE;
        end
      end
      default: rxSt_d = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxSt_q <= RX_IDLE;
    end else begin
      rxSt_q <= rxSt_d;
    end
  end

  // Carrier sense follows the J one clock later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      macRxDv <= 1'b0;
      macRxd <= 4'h0;
      macCrs <= 1'b0;
    end else if (isoActive_q) begin
      macRxDv <= 1'b0;
      macRxd <= 4'h0;
      macCrs <= 1'b0;
    end else if (lbk_q) begin
      macRxDv <= fifoPop && deadDone; // [R8]
      macRxd <= (fifoPop && deadDone) ? fifoOutData : 4'h0;
      macCrs <= fifoPop && deadDone;
    end else begin
      macRxDv <= rxSt_q == RX_DATA && rxSt_d == RX_DATA;
      macRxd <= (rxSt_q == RX_DATA) ? dec5b4b(lineRxCode) : 4'h0;
      macCrs <= rxSt_d != RX_IDLE; // [R1]
    end
  end

  // Cycles since the last reset release, for checking only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      since_q <= '0;
    end else if (srstNow) begin
      since_q <= '0;
    end else if (since_q != SINCE_W'(RST_ISO_CYC)) begin
      since_q <= SINCE_W'(since_q + 1'b1);
    end
  end

  crs_latency_a: assert property ( // [R1]
    @(posedge clk) disable iff (!rst_b)
    (rxSt_q == RX_IDLE && lineRxCode == CG_J && !isoActive_q && !lbk_q &&
     !srstNow) |-> ##[1:CRS_LIM] macCrs)
    else $error("carrier sense late after J");

  strap_latch_a: assert property ( // [R5]
    @(posedge clk) disable iff (!rst_b)
    (seqPh_q == SEQ_WAIT && !srstNow) ##1 (seqPh_q == SEQ_DRIVE)
    |-> since_q == SINCE_W'(STRAP_CYC))
    else $error("straps not latched at the set time");

  pin_drive_a: assert property ( // [R6]
    @(posedge clk) disable iff (!rst_b || srstNow)
    $rose(seqPh_q == SEQ_DRIVE) |-> (cfgPinOe_b == '1) ##DRV_LIM
    (cfgPinOe_b == '0))
    else $error("strap pins not driven on time");

  dead_time_a: assert property ( // [R8]
    @(posedge clk) disable iff (!rst_b)
    (lbk_q && !deadDone) |=> !macRxDv)
    else $error("receive data during loopback dead-time");

  line_quiet_a: assert property ( // [R9]
    @(posedge clk) disable iff (!rst_b)
    (lbk_q && !lbkXmt_q) |=> (!lineTxActive && lineTxCode == CG_OFF))
    else $error("line driven during loopback");

  xmt_enable_a: assert property ( // [R10]
    @(posedge clk) disable iff (!rst_b)
    (lbk_q && lbkXmt_q && !isoActive_q) |=> lineTxActive)
    else $error("loopback transmit enable ignored");

  iso_exit_a: assert property ( // [R11]
    @(posedge clk) disable iff (!rst_b)
    ($fell(ctrlIso_q) && seqPh_q == SEQ_RUN && !srstNow) |=> !isoActive_q
    ##1 !isoActive_q)
    else $error("isolate not left after clear");

  rst_iso_a: assert property ( // [R12]
    @(posedge clk) disable iff (!rst_b)
    (since_q == SINCE_W'(RST_ISO_CYC) && !ctrlIso_q && !srstNow)
    |=> !isoActive_q)
    else $error("still isolated long after reset");

  seq_count_a: assert property ( // [R13]
    @(posedge clk) disable iff (!rst_b)
    (seqPh_q == SEQ_DRIVE) |-> since_q == SINCE_W'(STRAP_CYC + seqCnt_q))
    else $error("sequence counter out of step");
endmodule
`default_nettype wire

/* File: tb/prilt_line_model.sv */
`default_nettype none
module prilt_line_model
  import prilt_pkg::*;
(
  // Clock and stall control
  input wire logic clk,
  input wire logic stall,
  // Line receive pair
  output logic [4:0] lineRxCode,
  // Line transmit pair
  input wire logic [4:0] lineTxCode,
  input wire logic lineTxActive,
  output logic lineTxReady,
  output var int codeCount
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle code between frames keeps the receiver out of carrier
  initial begin
    lineRxCode = CG_IDLE;
    codeCount = 0;
  end

  assign lineTxReady = !stall;

  always @(posedge clk) begin
    if (lineTxActive && lineTxReady && lineTxCode !== CG_IDLE) begin
      codeCount <= codeCount + 1;
    end
  end

  task automatic frame();
    logic [4:0] seq [7];
    seq = '{CG_J, CG_K, 5'h1E, 5'h09, 5'h14, CG_T, CG_IDLE};
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      lineRxCode <= seq[i];
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/prilt_top_tb.sv */
`default_nettype none
module prilt_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import prilt_pkg::*;

  localparam int DEAD = 20;
  localparam int FIFO_DEPTH_EXP = 4;
  logic clk = 0, rst_b = 0, stall = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] cfgPinIn = 4'hA, cfgPinOut, cfgPinOe_b;
  logic macTxEn = 0, macTxReady, macRxDv, macCrs, lineTxActive, lineTxReady;
  logic [3:0] macTxd = 0, macRxd;
  logic [4:0] lineRxCode, lineTxCode;
  int codeCount, numErrors = 0, testsRun = 0;
  logic [31:0] rd;
  logic [1:0] rsp;

  prilt_top #(.DEAD_CYCLES(DEAD)) dut (.clk, .rst_b, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cfgPinIn,
    .cfgPinOut, .cfgPinOe_b, .macTxEn, .macTxd, .macTxReady, .macRxDv,
    .macRxd, .macCrs, .lineRxCode, .lineTxCode, .lineTxActive,
    .lineTxReady);

  prilt_line_model u_line (.clk, .stall, .lineRxCode, .lineTxCode,
    .lineTxActive, .lineTxReady, .codeCount);

  always #20 clk = ~clk;

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      numErrors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic endOfTest();
    $display("checks %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (s_axi_awready === 1) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wready === 1) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clk); while (s_axi_arready !== 1);
    s_axi_arvalid <= 0;
    do @(posedge clk); while (s_axi_rvalid !== 1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask

  task automatic testStraps();
    repeat (70) @(posedge clk);
    check("oe before latch", cfgPinOe_b, 4'hF);
    repeat (10) @(posedge clk);
    check("oe after latch", cfgPinOe_b, 4'h0);
    cfgPinIn <= 4'h5;
    repeat (2) @(posedge clk);
    check("pins hold strap", cfgPinOut, 4'hA);
    axiRead(STRAP_OFS, rd, rsp);
    check("strap reg", rd[3:0], 4'hA);
    axiRead(STAT_OFS, rd, rsp);
    check("stat after reset", rd[2:0], 3'h6);
  endtask

  task automatic testUnmapped();
    axiWrite(8'h10, 32'hFFFF_FFFF, rsp);
    check("bresp unmapped", rsp, RESP_SLVERR);
    axiRead(8'h10, rd, rsp);
    check("rresp unmapped", rsp, RESP_SLVERR);
    check("rdata unmapped", rd, 32'h0);
  endtask

  task automatic testCarrier();
    int n;
    n = 0;
    fork
      u_line.frame();
      begin
        do begin
          @(posedge clk);
          n++;
        end while (macCrs !== 1 && n < 10);
      end
    join
    check("crs latency", n <= CRS_MAX_CYC + 1, 1'b1);
  endtask

  task automatic pushNibbles(input int cycles, output int n);
    n = 0;
    @(posedge clk);
    macTxEn <= 1;
    macTxd <= 4'h0;
    repeat (cycles) begin
      @(posedge clk);
      if (macTxReady === 1) begin
        n++;
        macTxd <= n[3:0];
      end
    end
    macTxEn <= 0;
  endtask

  task automatic testFifo();
    int n, c0;
    logic [4:0] first;
    first = CG_IDLE;
    stall <= 1;
    pushNibbles(10, n);
    check("fifo fill count", n, FIFO_DEPTH_EXP);
    c0 = codeCount;
    stall <= 0;
    repeat (20) begin
      @(posedge clk);
      if (first === CG_IDLE && lineTxActive === 1) first = lineTxCode;
    end
    check("drained codes", codeCount - c0, FIFO_DEPTH_EXP);
    check("first code", first, 5'h1E);
    check("line active", lineTxActive, 1'b1);
  endtask

  task automatic testLoopback();
    int n, c0, dv, late, bad;
    logic [3:0] last;
    dv = 0;
    late = 0;
    bad = 0;
    last = 4'h0;
    c0 = codeCount;
    axiWrite(CTRL_OFS, 32'h0000_4000, rsp);
    axiRead(STAT_OFS, rd, rsp);
    check("dead flag", rd[STAT_DEAD_BIT], 1'b1);
    check("line quiet", lineTxActive, 1'b0);
    fork
      pushNibbles(DEAD + 30, n);
      begin
        repeat (DEAD - 8) begin
          @(posedge clk);
          if (macRxDv === 1) dv++;
        end
        // Looped nibbles must come back in the order they were sent
        repeat (30) begin
          @(posedge clk);
          if (macRxDv === 1) begin
            if (late > 0 && macRxd !== 4'(last + 1)) bad++;
            last = macRxd;
            late++;
          end
        end
      end
    join
    check("blanked rx", dv, 0);
    check("no line codes", codeCount - c0, 0);
    check("looped rx", late >= 20, 1'b1);
    check("looped order", bad, 0);
    axiWrite(LOOP_OFS, 32'h0000_0001, rsp);
    repeat (2) @(posedge clk);
    check("line on in loop", lineTxActive, 1'b1);
    axiWrite(LOOP_OFS, 32'h0, rsp);
    axiWrite(CTRL_OFS, 32'h0, rsp);
  endtask

  task automatic testIsolate();
    axiWrite(CTRL_OFS, 32'h0000_0400, rsp);
    check("bresp okay", rsp, RESP_OKAY);
    axiRead(STAT_OFS, rd, rsp);
    check("isolated", rd[STAT_ISO_BIT], 1'b1);
    axiWrite(CTRL_OFS, 32'h0, rsp);
    axiRead(STAT_OFS, rd, rsp);
    check("isolate left", rd[STAT_ISO_BIT], 1'b0);
  endtask

  task automatic testSoftReset();
    // Software reset only once the hardware reset has long settled
    repeat (RST_ISO_CYC) @(posedge clk);
    axiWrite(CTRL_OFS, 32'h0000_8000, rsp);
    axiRead(CTRL_OFS, rd, rsp);
    check("srst busy", rd[CTRL_SRST_BIT], 1'b1);
    check("pins released", cfgPinOe_b, 4'hF);
    repeat (90) @(posedge clk);
    check("pins after srst", cfgPinOut, 4'h5);
    check("oe after srst", cfgPinOe_b, 4'h0);
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    numErrors++;
    endOfTest();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1;
    testStraps();
    testUnmapped();
    testCarrier();
    testFifo();
    testLoopback();
    testIsolate();
    testSoftReset();
    endOfTest();
  end
endmodule
`default_nettype wire
